// *** dv/wait_mode_fast_startup_tb.sv ***
`timescale 1ns/100ps
module wait_mode_fast_startup_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] strb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, fsu, rc_en, mclk_en, wact, irq;
    logic [1:0] bresp, rresp, flash;
    logic [15:0] wake;
    logic rtc, tmr_alarm, usb, evt;
    int miscompares = 0, cmp_count = 0, seed = 85;
    // expected status events, oldest first
    int stat_q[$];

    wait_mode_fast_startup i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wait_for_event_instruction(evt), .wake_input(wake),
        .rtc_alarm(rtc), .real_time_timer_alarm(tmr_alarm), .usb_alarm(usb),
        .fast_startup(fsu), .fast_rc_enable(rc_en), .master_clock_enable(mclk_en),
        .wait_mode_active(wact), .flash_power_state(flash), .irq(irq));
    wake_src_model i_src (.aclk(aclk), .wake_input(wake), .rtc_alarm(rtc),
        .real_time_timer_alarm(tmr_alarm), .usb_alarm(usb), .wait_for_event_instruction(evt));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tmo;
        chk(32'h0, 32'h1);
        finish_test();
    endtask

    // bready raised with the request: the master may accept the answer at once
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic done;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                chk(32'(bresp), 32'(er));
            end
        end
        if (!done) tmo();
    endtask

    task rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        logic done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                rready <= 1'b0;
                chk(32'(rresp), 32'(er));
            end
        end
        if (!done) tmo();
    endtask

    initial begin
        #800000;
        tmo();
    end

    initial begin
        logic [31:0] d;
        logic [15:0] pol;
        int k, n, stat, en, fl;
        fl = 2;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk(32'(flash), 32'h2);
        rd(12'h010, d, 2'h0);
        chk(32'(d[3]), 32'h1);
        wr(12'h004, 32'h1, 2'h0);
        rd(12'h004, d, 2'h0);
        chk(d, 32'h1);
        rd(12'h020, d, 2'h2);
        wr(12'h024, 32'h1, 2'h2);
        wr(12'h01c, 32'hffff_ffff, 2'h0);
        // unwritten byte lanes store zero
        strb <= 4'h1;
        wr(12'h00c, 32'hffff_ffff, 2'h0);
        strb <= 4'hf;
        rd(12'h00c, d, 2'h0);
        chk(d, 32'h0000_00ff);
        for (k = 0; k < 4; k++) begin
            en = (k == 0) ? 0 : 3;
            wr(12'h014, 32'(en), 2'h0);
            pol = 16'($random(seed));
            i_src.quiet(pol);
            wr(12'h00c, {16'h0, pol}, 2'h0);
            rd(12'h00c, d, 2'h0);
            chk(d, {16'h0, pol});
            wr(12'h008, {9'h0, 2'(k % 3), k[0], 4'h7, 16'hffff}, 2'h0);
            // flash stays active until the next wait period starts
            chk(32'(flash), 32'h2);
            fl = k % 3;
            if (k[0]) begin
                i_src.event_wait(1'b1);
                for (n = 0; n < 20 && wact !== 1'b1; n++) @(posedge aclk);
                if (wact !== 1'b1) tmo();
                i_src.event_wait(1'b0);
            end else begin
                wr(12'h000, 32'h4, 2'h0);
            end
            stat_q.push_back(1);
            // state register updates at the edge just passed
            #1;
            chk(32'(wact), 32'h1);
            chk(32'(flash), 32'(fl));
            chk(32'(mclk_en), 32'h0);
            chk(32'(rc_en), 32'h0);
            rd(12'h010, d, 2'h0);
            chk(32'(d[3]), 32'h0);
            i_src.fire(k, $unsigned($random(seed)) % 16);
            #1;
            chk(32'(fsu), 32'h1);
            chk(32'(rc_en), 32'h1);
            for (n = 0; n < 40 && d[3] !== 1'b1; n++) rd(12'h010, d, 2'h0);
            if (d[3] !== 1'b1) tmo();
            chk(32'(d[3]), 32'h1);
            chk(32'(wact), 32'h0);
            chk(32'(mclk_en), 32'h1);
            stat_q.push_back(2);
            stat = 0;
            while (stat_q.size() > 0) stat = stat | stat_q.pop_front();
            rd(12'h01c, d, 2'h0);
            chk(d, 32'(stat));
            chk(32'(irq), 32'((en & stat) != 0));
            i_src.quiet(pol);
            wr(12'h018, 32'h3, 2'h0);
            rd(12'h01c, d, 2'h0);
            chk(d, 32'h0);
            chk(32'(irq), 32'h0);
        end
        finish_test();
    end
endmodule

// *** dv/wake_src_model.sv ***
`timescale 1ns/100ps
module wake_src_model (
    input wire logic aclk,
    output logic [15:0] wake_input,
    output logic rtc_alarm,
    output logic real_time_timer_alarm,
    output logic usb_alarm,
    output logic wait_for_event_instruction
);
    logic [15:0] pol_r = 16'h0000;
    initial begin
        wake_input = 16'hffff;
        rtc_alarm = 1'b0;
        real_time_timer_alarm = 1'b0;
        usb_alarm = 1'b0;
        wait_for_event_instruction = 1'b0;
    end
    task quiet(input logic [15:0] pol);
        @(posedge aclk);
        pol_r = pol;
        wake_input <= ~pol;
        rtc_alarm <= 1'b0;
        real_time_timer_alarm <= 1'b0;
        usb_alarm <= 1'b0;
    endtask
    task fire(input int src, input int idx);
        @(posedge aclk);
        case (src)
            0: wake_input[idx] <= pol_r[idx];
            1: rtc_alarm <= 1'b1;
            2: real_time_timer_alarm <= 1'b1;
            default: usb_alarm <= 1'b1;
        endcase
    endtask
    task event_wait(input logic v);
        @(posedge aclk);
        wait_for_event_instruction <= v;
    endtask
endmodule

// *** rtl/wait_mode_defs.svh ***
// Operation
// - setting wait request bit in oscillator control register enters wait mode
// - wait-for-event with low-power select set also enters wait mode
// - any enabled one of 16 wake inputs at programmed level, or an enabled alarm, starts up
// - each wake input polarity individually set by polarity register
// - startup detection is clockless, combining sources into one signal
// - fast rc oscillator restarts automatically when startup signal asserts
// - flash select: 0 standby, 1 deep power-down, 2 active without reads
// - flash select writable anytime, latched at start of next wait period
`ifndef WAIT_MODE_DEFS_SVH
`define WAIT_MODE_DEFS_SVH
`define OFS_MAIN_OSC_CTRL 12'h000
`define OFS_MCLK_CFG 12'h004
`define OFS_FSTART_MODE 12'h008
`define OFS_FSTART_POL 12'h00c
`define OFS_PWR_STATUS 12'h010
`define OFS_IRQ_EN 12'h014
`define OFS_IRQ_CLR 12'h018
`define OFS_IRQ_STAT 12'h01c
`define BIT_WAIT_REQ 2
`define BIT_FSM_TMR 16
`define BIT_FSM_RTC 17
`define BIT_FSM_USB 18
`define BIT_LP_EVT 20
`define FLASH_SEL_LSB 21
`define BIT_MCLK_RDY 3
`define CLK_SRC_FAST_RC 2'h1
`define MCLK_CFG_RST 32'h0000_0001
`define FLASH_STATE_RST 2'h2
`define RESUME_TIME_NS 100
`define RESUME_CYCLES ((`RESUME_TIME_NS + 9) / 10)
`endif

// *** rtl/wait_mode_fast_startup.sv ***
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "wait_mode_defs.svh"
module wait_mode_fast_startup (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wait_for_event_instruction,
    input wire logic [15:0] wake_input,
    input wire logic rtc_alarm,
    input wire logic real_time_timer_alarm,
    input wire logic usb_alarm,
    output logic fast_startup,
    output logic fast_rc_enable,
    output logic master_clock_enable,
    output logic wait_mode_active,
    output logic [1:0] flash_power_state,
    output logic irq
);
    logic [31:0] osc_ctrl_r, osc_ctrl_nxt;
    logic [31:0] mclk_cfg_r, mclk_cfg_nxt;
    logic [31:0] fs_mode_r, fs_mode_nxt;
    logic [15:0] fs_pol_r, fs_pol_nxt;
    logic [1:0] irq_en_r, irq_en_nxt;
    logic [1:0] irq_st_r, irq_st_nxt;
    logic rdy_r, rdy_nxt;
    logic [1:0] flash_r, flash_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    wait_mode_pkg::pwr_state_t st_r, st_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [15:0] wake_hit;
    logic do_write, enter_wait, startup_evt;
    logic [31:0] wr_merged;

    // per-input level compare, no clock involved
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_wake
            assign wake_hit[gi] = fs_mode_r[gi] & ~(wake_input[gi] ^ fs_pol_r[gi]);
        end
    endgenerate

    assign fast_startup = (|wake_hit)
        | (rtc_alarm & fs_mode_r[`BIT_FSM_RTC])
        | (real_time_timer_alarm & fs_mode_r[`BIT_FSM_TMR])
        | (usb_alarm & fs_mode_r[`BIT_FSM_USB]);
    assign fast_rc_enable = (st_r != wait_mode_pkg::ST_WAIT) | fast_startup;
    assign master_clock_enable = (st_r == wait_mode_pkg::ST_RUN);
    assign wait_mode_active = (st_r == wait_mode_pkg::ST_WAIT);
    assign flash_power_state = flash_r;
    assign irq = |(irq_st_r & irq_en_r);

    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready = ~w_got_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    always_comb begin
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0] s;
        a = aw_got_r ? awaddr_r : s_axi_awaddr;
        d = w_got_r ? wdata_r : s_axi_wdata;
        s = w_got_r ? wstrb_r : s_axi_wstrb;
        aw_got_nxt = aw_got_r | (s_axi_awvalid & s_axi_awready);
        w_got_nxt = w_got_r | (s_axi_wvalid & s_axi_wready);
        awaddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_r;
        wdata_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
        wstrb_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_r;
        do_write = aw_got_nxt & w_got_nxt & ~bvalid_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        osc_ctrl_nxt = osc_ctrl_r;
        mclk_cfg_nxt = mclk_cfg_r;
        fs_mode_nxt = fs_mode_r;
        fs_pol_nxt = fs_pol_r;
        irq_en_nxt = irq_en_r;
        irq_st_nxt = irq_st_r;
        wr_merged = 32'h0000_0000;
        if (bvalid_r & s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_write) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = 2'h0;
            for (int i = 0; i < 4; i++) begin
                wr_merged[8*i +: 8] = s[i] ? d[8*i +: 8] : 8'h00;
            end
            unique case (a)
                `OFS_MAIN_OSC_CTRL: osc_ctrl_nxt = wr_merged;
                `OFS_MCLK_CFG: mclk_cfg_nxt = wr_merged;
                `OFS_FSTART_MODE: fs_mode_nxt = wr_merged;
                `OFS_FSTART_POL: fs_pol_nxt = wr_merged[15:0];
                `OFS_IRQ_EN: irq_en_nxt = wr_merged[1:0];
                `OFS_IRQ_CLR: irq_st_nxt = irq_st_r & ~wr_merged[1:0];
                `OFS_PWR_STATUS, `OFS_IRQ_STAT: bresp_nxt = 2'h0;
                default: bresp_nxt = 2'h2;
            endcase
        end
        // wait request bit self clears on entry
        if (enter_wait) begin
            osc_ctrl_nxt[`BIT_WAIT_REQ] = 1'b0;
        end
        // set beats clear: wait entry, wake
        if (enter_wait) begin
            irq_st_nxt[0] = 1'b1;
        end
        if (startup_evt) begin
            irq_st_nxt[1] = 1'b1;
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r & s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = 2'h0;
            unique case (s_axi_araddr)
                `OFS_MAIN_OSC_CTRL: rdata_nxt = osc_ctrl_r;
                `OFS_MCLK_CFG: rdata_nxt = mclk_cfg_r;
                `OFS_FSTART_MODE: rdata_nxt = fs_mode_r;
                `OFS_FSTART_POL: rdata_nxt = {16'h0000, fs_pol_r};
                `OFS_PWR_STATUS: rdata_nxt = {28'h0000000, rdy_r, 3'h0};
                `OFS_IRQ_EN: rdata_nxt = {30'h00000000, irq_en_r};
                `OFS_IRQ_CLR: rdata_nxt = 32'h0000_0000;
                `OFS_IRQ_STAT: rdata_nxt = {30'h00000000, irq_st_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = 2'h2;
                end
            endcase
        end
    end

    assign enter_wait = (st_r == wait_mode_pkg::ST_RUN)
        & (osc_ctrl_r[`BIT_WAIT_REQ]
           | (wait_for_event_instruction & fs_mode_r[`BIT_LP_EVT]));
    assign startup_evt = (st_r == wait_mode_pkg::ST_WAIT) & fast_startup;

    always_comb begin
        st_nxt = st_r;
        rdy_nxt = rdy_r;
        flash_nxt = flash_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            wait_mode_pkg::ST_RUN: begin
                if (enter_wait) begin
                    st_nxt = wait_mode_pkg::ST_WAIT;
                    rdy_nxt = 1'b0;
                    flash_nxt = fs_mode_r[`FLASH_SEL_LSB +: 2];
                end
            end
            wait_mode_pkg::ST_WAIT: begin
                if (fast_startup) begin
                    st_nxt = wait_mode_pkg::ST_RESUME;
                    cnt_nxt = 4'(`RESUME_CYCLES);
                end
            end
            wait_mode_pkg::ST_RESUME: begin
                if (cnt_r == 4'h1) begin
                    st_nxt = wait_mode_pkg::ST_RUN;
                    rdy_nxt = 1'b1;
                    flash_nxt = wait_mode_pkg::FLASH_IDLE_ACTIVE;
                end
                cnt_nxt = cnt_r - 4'h1;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_ctrl_r <= 32'h0000_0000;
            mclk_cfg_r <= `MCLK_CFG_RST;
            fs_mode_r <= 32'h0000_0000;
            fs_pol_r <= 16'h0000;
            irq_en_r <= 2'h0;
            irq_st_r <= 2'h0;
            rdy_r <= 1'b1;
            flash_r <= `FLASH_STATE_RST;
            cnt_r <= 4'h0;
            st_r <= wait_mode_pkg::ST_RUN;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            osc_ctrl_r <= osc_ctrl_nxt;
            mclk_cfg_r <= mclk_cfg_nxt;
            fs_mode_r <= fs_mode_nxt;
            fs_pol_r <= fs_pol_nxt;
            irq_en_r <= irq_en_nxt;
            irq_st_r <= irq_st_nxt;
            rdy_r <= rdy_nxt;
            flash_r <= flash_nxt;
            cnt_r <= cnt_nxt;
            st_r <= st_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    property p_wait_entry;
        @(posedge aclk) disable iff (!aresetn)
        enter_wait |=> wait_mode_active && !rdy_r;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("no wait entry");
    property p_evt_entry;
        @(posedge aclk) disable iff (!aresetn)
        (st_r == wait_mode_pkg::ST_RUN) && wait_for_event_instruction
            && fs_mode_r[`BIT_LP_EVT] |=> wait_mode_active;
    endproperty
    a_evt_entry: assert property (p_evt_entry) else $error("event wait not entered");
    property p_startup_leave;
        @(posedge aclk) disable iff (!aresetn)
        startup_evt |-> ##[10:12] (rdy_r && master_clock_enable);
    endproperty
    a_startup_leave: assert property (p_startup_leave) else $error("no resume");
    property p_rc_restart;
        @(posedge aclk) disable iff (!aresetn)
        fast_startup |-> fast_rc_enable;
    endproperty
    a_rc_restart: assert property (p_rc_restart) else $error("rc not restarted");
    property p_flash_latch;
        @(posedge aclk) disable iff (!aresetn)
        enter_wait |=> flash_power_state == $past(fs_mode_r[`FLASH_SEL_LSB +: 2]);
    endproperty
    a_flash_latch: assert property (p_flash_latch) else $error("flash not latched");
    property p_flash_hold;
        @(posedge aclk) disable iff (!aresetn)
        wait_mode_active && $past(wait_mode_active) |-> $stable(flash_power_state);
    endproperty
    a_flash_hold: assert property (p_flash_hold) else $error("flash changed in wait");
    property p_wake_pol;
        @(posedge aclk) disable iff (!aresetn)
        (fs_mode_r[0] && (wake_input[0] == fs_pol_r[0])) |-> fast_startup;
    endproperty
    a_wake_pol: assert property (p_wake_pol) else $error("wake0 missed");
    property p_no_false_start;
        @(posedge aclk) disable iff (!aresetn)
        (fs_mode_r[18:0] == 19'h00000) |-> !fast_startup;
    endproperty
    a_no_false_start: assert property (p_no_false_start) else $error("spurious");
    property p_alarm;
        @(posedge aclk) disable iff (!aresetn)
        rtc_alarm && fs_mode_r[`BIT_FSM_RTC] |-> fast_startup;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm missed");
    // wait and ready invariants
    // request must not linger, or run would drop straight back into wait
    property p_req_clear;
        @(posedge aclk) disable iff (!aresetn)
        enter_wait |=> !osc_ctrl_r[`BIT_WAIT_REQ];
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("wait request kept");
    property p_wait_hold;
        @(posedge aclk) disable iff (!aresetn)
        wait_mode_active && !fast_startup |=> wait_mode_active;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("left wait unasked");
    property p_rdy_low_wait;
        @(posedge aclk) disable iff (!aresetn)
        wait_mode_active |-> !rdy_r;
    endproperty
    a_rdy_low_wait: assert property (p_rdy_low_wait) else $error("ready in wait");
    property p_resume_state;
        @(posedge aclk) disable iff (!aresetn)
        startup_evt |=> !wait_mode_active && !master_clock_enable;
    endproperty
    a_resume_state: assert property (p_resume_state) else $error("no resume");
    // ready only ever comes back together with the clock
    property p_rdy_rise;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rdy_r) |-> master_clock_enable;
    endproperty
    a_rdy_rise: assert property (p_rdy_rise) else $error("ready before clock");
    // flash back to active whenever the clock runs
    property p_flash_run;
        @(posedge aclk) disable iff (!aresetn)
        master_clock_enable |-> flash_power_state == 2'h2;
    endproperty
    a_flash_run: assert property (p_flash_run) else $error("flash low in run");
    property p_rc_off;
        @(posedge aclk) disable iff (!aresetn)
        wait_mode_active && !fast_startup |-> !fast_rc_enable;
    endproperty
    a_rc_off: assert property (p_rc_off) else $error("rc on in quiet wait");
    c_wait: cover property (@(posedge aclk) disable iff (!aresetn) enter_wait);
    c_wake: cover property (@(posedge aclk) disable iff (!aresetn) startup_evt);
    c_deep: cover property (@(posedge aclk) disable iff (!aresetn)
        wait_mode_active && flash_power_state == 2'h1);
endmodule

// *** rtl/wait_mode_pkg.sv ***
package wait_mode_pkg;
    typedef enum logic [1:0] {
        FLASH_STANDBY = 2'h0,
        FLASH_DEEP_PD = 2'h1,
        FLASH_IDLE_ACTIVE = 2'h2
    } flash_lp_t;
    typedef enum {ST_RUN, ST_WAIT, ST_RESUME} pwr_state_t;
endpackage
